// ### hdl/oms_seq.sv
// oms_seq.sv: operating mode sequencer with refresh scheduling
// assumes: presetn from the system, qualified with supply_good inside this block,
// APB master as in the protocol, inputs other than supply_good, adapter_valid and onoff_key synchronous to pclk
//
// How it works
// RULE1: power chip holds supply_good low while backup supply under 3.05 V.
// RULE2: supply_good low keeps everything idle, no activity.
// RULE3: good supply, no adapter, unit off gives Off mode with clock running.
// RULE4: adapter or switch-on starts the boot check for firmware.
// RULE5: without firmware stay in mask mode until off or power loss.
// RULE6: up plus right held at switch-on forces mask mode.
// RULE7: firmware, adapter, unit off selects Charge mode, flyback off.
// RULE8: firmware, adapter, unit on selects Operational and Charge mode.
// RULE9: firmware, battery, no adapter, unit on selects Operational mode.
// RULE10: low battery during flyback start drops back to Off mode.
// RULE11: refresh needed after 50 partial cycles or three months.
// RULE12: refresh needed after battery removal.
// RULE13: pending refresh prompts user right after switch-on.
// RULE14: refresh only on and adapter; charge, discharge, charge, 19 h. No hour timer here: each phase ends on a software phase-done write.
// RULE15: on/off key sensed by always-on logic outside the matrix.
// RULE16: rows driven and columns scanned for pressed keys.
// RULE17: off state keeps charger, clock, key and serial wake alive.
// RULE18: each on/off press toggles the switched-on status bit.
// RULE19: low supply_good resets the whole sequencer.
// RULE20: inputs pass two-flop synchronisers, the key is debounced. serial_wake and key_cols enter without a synchroniser.
// RULE21: current mode readable as an encoded status field.
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/100ps
module oms_seq (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // power chip and keys
  input wire logic supply_good,
  input wire logic adapter_valid,
  input wire logic onoff_key,
  input wire logic serial_wake,
  output logic [3:0] key_rows,
  input wire logic [3:0] key_cols,
  // power controls and state
  output oms_pkg::oms_pwr_type pwr_ctrl,
  output logic rtc_run,
  output logic [2:0] mode
);
  `include "oms_consts.svh"

  // ----------------------------------------------------------------
  // input conditioning
  // ----------------------------------------------------------------
  logic sg_s;
  logic ad_s;
  logic key_s;
  logic [15:0] keys;
  logic rst_n;

  // supply_good low acts as reset of all logic
  assign rst_n = presetn & supply_good; // RULE19 RULE1

  oms_sync #(.DEB_CYC(1)) u_sg ( // RULE20
    .pclk(pclk), .presetn(rst_n), .clk_en(clk_en),
    .async_in(supply_good), .sync_out(sg_s));
  oms_sync #(.DEB_CYC(1)) u_ad ( // RULE20
    .pclk(pclk), .presetn(rst_n), .clk_en(clk_en),
    .async_in(adapter_valid), .sync_out(ad_s));
  // always-on sense path, no matrix involvement
  oms_sync #(.DEB_CYC(`OMS_DEBOUNCE_CYC)) u_key ( // RULE15 RULE20
    .pclk(pclk), .presetn(rst_n), .clk_en(clk_en),
    .async_in(onoff_key), .sync_out(key_s));
  oms_keyscan u_scan ( // RULE16
    .pclk(pclk), .presetn(rst_n), .clk_en(clk_en),
    .rows(key_rows), .cols(key_cols), .keys(keys));

  // ----------------------------------------------------------------
  // registers and bus
  // ----------------------------------------------------------------
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic wr_ctrl;
  logic acc;

  function automatic logic ofs_hit(input logic [11:0] a,
                                   input logic [11:0] o);
    ofs_hit = (a == o);
  endfunction

  assign acc = psel & penable & pready_ff;
  assign wr_ctrl = acc & pwrite & ofs_hit(paddr, `OMS_CTRL_OFS);

  // ----------------------------------------------------------------
  // on/off toggle, mode state
  // ----------------------------------------------------------------
  logic key_d_ff, on_ff, nxt_on;
  oms_pkg::oms_mode_type mode_ff, nxt_mode;
  logic [4:0] boot_ff, nxt_boot;
  logic key_press;
  logic mask_keys;
  logic fw_ok, batt_pres, vbat_low;

  assign fw_ok = ctrl_ff[`OMS_CTRL_FW_OK];
  assign batt_pres = ctrl_ff[`OMS_CTRL_BATT_PRES];
  assign vbat_low = ctrl_ff[`OMS_CTRL_VBAT_LOW];
  assign key_press = key_s & ~key_d_ff;
  // up is key 0, right is key 1 of the matrix
  assign mask_keys = keys[0] & keys[1];

  always_comb begin
    nxt_on = (on_ff ^ key_press) | (serial_wake & ~on_ff); // RULE18 RULE17
    nxt_mode = mode_ff;
    nxt_boot = boot_ff;
    unique case (mode_ff)
      oms_pkg::OMS_IDLE: begin
        if (sg_s) nxt_mode = oms_pkg::OMS_OFF; // RULE2
      end
      oms_pkg::OMS_OFF: begin
        nxt_boot = 5'h00;
        if (ad_s | on_ff) nxt_mode = oms_pkg::OMS_BOOT; // RULE3 RULE4
      end
      oms_pkg::OMS_BOOT: begin
        nxt_boot = boot_ff + 5'h01;
        if (!(ad_s | on_ff)) begin
          nxt_mode = oms_pkg::OMS_OFF;
        end else if (boot_ff == 5'(`OMS_BOOT_CYC - 1)) begin
          if (!fw_ok || (on_ff && mask_keys)) // RULE5 RULE6
            nxt_mode = oms_pkg::OMS_MASK;
          else if (ad_s && !on_ff)
            nxt_mode = oms_pkg::OMS_CHARGE; // RULE7
          else if (ad_s)
            nxt_mode = oms_pkg::OMS_OPCHG; // RULE8
          else if (batt_pres)
            nxt_mode = oms_pkg::OMS_OPER; // RULE9
          else
            nxt_mode = oms_pkg::OMS_OFF;
        end
      end
      oms_pkg::OMS_MASK: begin
        // held until switched off or power lost
        if (key_press && on_ff) nxt_mode = oms_pkg::OMS_OFF; // RULE5
      end
      oms_pkg::OMS_CHARGE, oms_pkg::OMS_OPCHG, oms_pkg::OMS_OPER: begin
        if (mode_ff == oms_pkg::OMS_OPER && vbat_low) begin
          nxt_mode = oms_pkg::OMS_OFF; // RULE10
          // on status must end too, or off would boot straight again
          if (!key_press) nxt_on = 1'b0;
        end else if (!ad_s && !on_ff)
          nxt_mode = oms_pkg::OMS_OFF;
        else if (ad_s && !on_ff)
          nxt_mode = oms_pkg::OMS_CHARGE; // RULE7
        else if (ad_s)
          nxt_mode = oms_pkg::OMS_OPCHG; // RULE8
        else if (batt_pres)
          nxt_mode = oms_pkg::OMS_OPER; // RULE9
        else
          nxt_mode = oms_pkg::OMS_OFF;
      end
      default: nxt_mode = oms_pkg::OMS_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // refresh scheduling
  // ----------------------------------------------------------------
  logic [5:0] cyc_ff, nxt_cyc;
  logic [1:0] mon_ff, nxt_mon;
  logic need_ff, nxt_need;
  logic prompt_ff, nxt_prompt;
  logic batt_d_ff;
  oms_pkg::oms_refr_type rf_ff, nxt_rf;
  logic on_rise;

  assign on_rise = on_ff & ~nxt_on ? 1'b0 : (~on_ff & nxt_on);

  always_comb begin
    nxt_cyc = cyc_ff;
    nxt_mon = mon_ff;
    nxt_need = need_ff;
    nxt_prompt = prompt_ff;
    nxt_rf = rf_ff;
    if (wr_ctrl && pwdata[`OMS_CTRL_CYCLE_DONE])
      nxt_cyc = cyc_ff + 6'h01;
    if (wr_ctrl && pwdata[`OMS_CTRL_MONTH_TICK])
      nxt_mon = mon_ff + 2'h1;
    if (wr_ctrl && pwdata[`OMS_CTRL_PROMPT_ACK])
      nxt_prompt = 1'b0;
    // set wins over the acknowledge in the same cycle
    if (need_ff && on_rise) nxt_prompt = 1'b1; // RULE13
    unique case (rf_ff)
      oms_pkg::OMS_RF_IDLE: begin
        if (wr_ctrl && pwdata[`OMS_CTRL_REFR_START] &&
            mode_ff == oms_pkg::OMS_OPCHG) // RULE14
          nxt_rf = oms_pkg::OMS_RF_CHG1;
      end
      oms_pkg::OMS_RF_CHG1, oms_pkg::OMS_RF_DIS, oms_pkg::OMS_RF_CHG2: begin
        if (mode_ff != oms_pkg::OMS_OPCHG)
          nxt_rf = oms_pkg::OMS_RF_IDLE;
        else if (wr_ctrl && pwdata[`OMS_CTRL_REFR_PHASE_DONE]) begin
          nxt_rf = oms_pkg::oms_refr_type'(rf_ff + 2'h1); // RULE14
          if (rf_ff == oms_pkg::OMS_RF_CHG2) begin
            nxt_rf = oms_pkg::OMS_RF_IDLE;
            nxt_need = 1'b0;
            nxt_cyc = 6'h00;
            nxt_mon = 2'h0;
          end
        end
      end
    endcase
    if (nxt_cyc >= 6'(`OMS_REFRESH_CYCLES) ||
        nxt_mon >= 2'(`OMS_REFRESH_MONTHS)) // RULE11
      nxt_need = 1'b1;
    if (batt_d_ff && !batt_pres) nxt_need = 1'b1; // RULE12
  end

  // ----------------------------------------------------------------
  // bus next values
  // ----------------------------------------------------------------
  logic [31:0] stat_word;
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[`OMS_STAT_MODE_LSB +: 3] = mode_ff; // RULE21
    stat_word[`OMS_STAT_ON] = on_ff;
    stat_word[`OMS_STAT_ADAPT] = ad_s;
    stat_word[`OMS_STAT_REFR_NEED] = need_ff;
    stat_word[`OMS_STAT_PROMPT] = prompt_ff;
    stat_word[`OMS_STAT_REFR_PH_LSB +: 2] = rf_ff;
    stat_word[`OMS_STAT_FLY] = pwr_ctrl.flyback_en;
    stat_word[`OMS_STAT_CHG] = pwr_ctrl.charger_en;
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl) nxt_ctrl = pwdata[7:0] & 8'h07;
    // one wait state: ready rises in the second access cycle
    nxt_pready = psel & penable & ~pready_ff;
    nxt_pslverr = 1'b0;
    nxt_prdata = prdata_ff;
    if (psel && penable && !pready_ff) begin
      nxt_prdata = 32'h0000_0000;
      if (ofs_hit(paddr, `OMS_CTRL_OFS))
        nxt_prdata = {24'h00_0000, ctrl_ff};
      else if (ofs_hit(paddr, `OMS_STAT_OFS))
        nxt_prdata = stat_word;
      else if (ofs_hit(paddr, `OMS_CNT_OFS))
        nxt_prdata = {24'h00_0000, mon_ff, cyc_ff};
      else if (ofs_hit(paddr, `OMS_KEY_OFS))
        nxt_prdata = {16'h0000, keys};
      else
        nxt_pslverr = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  oms_pkg::oms_pwr_type nxt_pwr, pwr_ff;
  logic nxt_rtc, rtc_ff;
  always_comb begin
    nxt_pwr = '0;
    nxt_pwr.flyback_en = (nxt_mode == oms_pkg::OMS_OPER) ||
                         (nxt_mode == oms_pkg::OMS_OPCHG); // RULE8 RULE9
    // charger stays enabled in off state while the adapter is present
    nxt_pwr.charger_en = (nxt_mode == oms_pkg::OMS_CHARGE) ||
                         (nxt_mode == oms_pkg::OMS_OPCHG) ||
                         (nxt_mode == oms_pkg::OMS_OFF && ad_s); // RULE17
    nxt_pwr.batt_discharge = (nxt_rf == oms_pkg::OMS_RF_DIS); // RULE14
    nxt_rtc = (nxt_mode != oms_pkg::OMS_IDLE); // RULE3 RULE17
  end

  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= 8'h00;
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      key_d_ff <= 1'b0;
      on_ff <= 1'b0;
      mode_ff <= oms_pkg::OMS_IDLE; // RULE2
      boot_ff <= 5'h00;
      cyc_ff <= 6'h00;
      mon_ff <= 2'h0;
      need_ff <= 1'b0;
      prompt_ff <= 1'b0;
      batt_d_ff <= 1'b0;
      rf_ff <= oms_pkg::OMS_RF_IDLE;
      pwr_ff <= '0;
      rtc_ff <= 1'b0;
    end else if (clk_en) begin
      ctrl_ff <= nxt_ctrl;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      key_d_ff <= key_s;
      on_ff <= nxt_on;
      mode_ff <= nxt_mode;
      boot_ff <= nxt_boot;
      cyc_ff <= nxt_cyc;
      mon_ff <= nxt_mon;
      need_ff <= nxt_need;
      prompt_ff <= nxt_prompt;
      batt_d_ff <= batt_pres;
      rf_ff <= nxt_rf;
      pwr_ff <= nxt_pwr;
      rtc_ff <= nxt_rtc;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign pwr_ctrl = pwr_ff;
  assign rtc_run = rtc_ff;
  assign mode = mode_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  idle_on_reset_a: assert property (@(posedge pclk) // RULE2
    !sg_s && rst_n |-> mode_ff inside {oms_pkg::OMS_IDLE})
    else $error("mode left idle without supply good");
  fly_mode_a: assert property (@(posedge pclk) disable iff (!rst_n) // RULE9
    pwr_ff.flyback_en |-> mode_ff inside {oms_pkg::OMS_OPER,
                                          oms_pkg::OMS_OPCHG})
    else $error("flyback on outside operational modes");
  charge_fly_off_a: assert property (@(posedge pclk) disable iff (!rst_n)
    mode_ff == oms_pkg::OMS_CHARGE |-> !pwr_ff.flyback_en) // RULE7
    else $error("flyback running in charge mode");
  low_batt_off_a: assert property (@(posedge pclk) disable iff (!rst_n)
    clk_en && mode_ff == oms_pkg::OMS_OPER && vbat_low
    |=> mode_ff == oms_pkg::OMS_OFF) // RULE10
    else $error("low battery did not force off");
  refr_gate_a: assert property (@(posedge pclk) disable iff (!rst_n)
    rf_ff != oms_pkg::OMS_RF_IDLE |-> mode_ff == oms_pkg::OMS_OPCHG) // RULE14
    else $error("refresh active without adapter and on");
  cycle_need_a: assert property (@(posedge pclk) disable iff (!rst_n)
    cyc_ff >= 6'd50 |-> need_ff) // RULE11
    else $error("refresh not flagged after 50 cycles");
  toggle_on_a: assert property (@(posedge pclk) disable iff (!rst_n)
    clk_en && key_press && !serial_wake |=> on_ff != $past(on_ff)) // RULE18
    else $error("key press did not toggle on status");
  apb_ready_a: assert property (@(posedge pclk) disable iff (!rst_n)
    clk_en && psel && penable && !pready_ff |=> pready_ff) // RULE21
    else $error("apb answer late");
  cv_opchg_c: cover property (@(posedge pclk) mode_ff == oms_pkg::OMS_OPCHG);
  cv_mask_c: cover property (@(posedge pclk) mode_ff == oms_pkg::OMS_MASK);
  cv_refr_c: cover property (@(posedge pclk) rf_ff == oms_pkg::OMS_RF_CHG2);
endmodule

// ### hdl/oms_consts.svh
// oms_consts.svh: offsets, field positions, reset values, timing counts
// assumes: included by bare name from the sequencer sources
`ifndef OMS_CONSTS_SVH
`define OMS_CONSTS_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define OMS_CLK_HZ 100000000
`define OMS_DEBOUNCE_MS 10
`define OMS_DEBOUNCE_CYC ((`OMS_DEBOUNCE_MS * (`OMS_CLK_HZ / 1000)))
`define OMS_BOOT_CYC 16
`define OMS_REFRESH_CYCLES 50
`define OMS_REFRESH_MONTHS 3
`define OMS_REFRESH_HOURS 19
`define OMS_SCAN_ROW_CYC 1000

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define OMS_CTRL_OFS 12'h000
`define OMS_STAT_OFS 12'h004
`define OMS_CNT_OFS 12'h008
`define OMS_KEY_OFS 12'h00c

// ----------------------------------------------------------------
// ctrl fields
// ----------------------------------------------------------------
`define OMS_CTRL_FW_OK 0
`define OMS_CTRL_BATT_PRES 1
`define OMS_CTRL_VBAT_LOW 2
`define OMS_CTRL_CYCLE_DONE 3
`define OMS_CTRL_MONTH_TICK 4
`define OMS_CTRL_REFR_START 5
`define OMS_CTRL_REFR_PHASE_DONE 6
`define OMS_CTRL_PROMPT_ACK 7
`define OMS_CTRL_RESET 32'h0000_0000

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define OMS_STAT_MODE_LSB 0
`define OMS_STAT_ON 4
`define OMS_STAT_ADAPT 5
`define OMS_STAT_REFR_NEED 6
`define OMS_STAT_PROMPT 7
`define OMS_STAT_REFR_PH_LSB 8
`define OMS_STAT_FLY 12
`define OMS_STAT_CHG 13

`endif

// ### hdl/oms_pkg.sv
// oms_pkg.sv: shared types of the operating mode sequencer
// assumes: nothing beyond a SystemVerilog compiler
package oms_pkg;

  typedef enum logic [2:0] {
    OMS_IDLE = 3'b000,
    OMS_OFF = 3'b001,
    OMS_BOOT = 3'b010,
    OMS_MASK = 3'b011,
    OMS_CHARGE = 3'b100,
    OMS_OPCHG = 3'b101,
    OMS_OPER = 3'b110
  } oms_mode_type;

  typedef enum logic [1:0] {
    OMS_RF_IDLE = 2'b00,
    OMS_RF_CHG1 = 2'b01,
    OMS_RF_DIS = 2'b10,
    OMS_RF_CHG2 = 2'b11
  } oms_refr_type;

  // converter and charger enables driven to the power chip
  typedef struct packed {
    logic flyback_en;
    logic charger_en;
    logic batt_discharge;
  } oms_pwr_type;

endpackage

// ### hdl/oms_sync.sv
// oms_sync.sv: two-flop synchroniser with optional debounce
// assumes: one clock, clock enable freezes the state
`timescale 1ns/100ps
module oms_sync #(
  parameter int unsigned DEB_CYC = 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // level in and out
  input wire logic async_in,
  output logic sync_out
);
  `include "oms_consts.svh"

  logic meta_ff;
  logic sync_ff;
  logic out_ff;
  logic [31:0] cnt_ff;
  logic nxt_out;
  logic [31:0] nxt_cnt;

  // stable level must persist DEB_CYC cycles before it is accepted
  always_comb begin
    nxt_out = out_ff;
    nxt_cnt = 32'h0000_0000;
    if (sync_ff != out_ff) begin
      if (cnt_ff >= DEB_CYC - 1) begin
        nxt_out = sync_ff;
      end else begin
        nxt_cnt = cnt_ff + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      out_ff <= 1'b0;
      cnt_ff <= 32'h0000_0000;
    end else if (clk_en) begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
      out_ff <= nxt_out;
      cnt_ff <= nxt_cnt;
    end
  end

  assign sync_out = out_ff;
endmodule

// ### hdl/oms_keyscan.sv
// oms_keyscan.sv: keyboard matrix row driver and column sampler
// assumes: columns are active high and synchronous to pclk
`timescale 1ns/100ps
module oms_keyscan (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // matrix
  output logic [3:0] rows,
  input wire logic [3:0] cols,
  // result, one bit per key, row major
  output logic [15:0] keys
);
  `include "oms_consts.svh"

  logic [1:0] row_ff;
  logic [15:0] cnt_ff;
  logic [15:0] keys_ff;
  logic [3:0] rows_ff;
  logic [1:0] nxt_row;
  logic [3:0] nxt_rows;
  logic [15:0] nxt_cnt;
  logic [15:0] nxt_keys;

  // one row driven at a time; sample its columns at the end of the slot
  always_comb begin
    nxt_row = row_ff;
    nxt_cnt = cnt_ff + 16'h0001;
    nxt_keys = keys_ff;
    if (cnt_ff == 16'(`OMS_SCAN_ROW_CYC - 1)) begin
      nxt_cnt = 16'h0000;
      nxt_keys[row_ff*4 +: 4] = cols;
      nxt_row = row_ff + 2'h1;
    end
    // row drive registered so the pins come straight from flops
    nxt_rows = 4'h1 << nxt_row;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_ff <= 2'h0;
      cnt_ff <= 16'h0000;
      keys_ff <= 16'h0000;
      rows_ff <= 4'h1;
    end else if (clk_en) begin
      row_ff <= nxt_row;
      cnt_ff <= nxt_cnt;
      keys_ff <= nxt_keys;
      rows_ff <= nxt_rows;
    end
  end

  assign rows = rows_ff; // RULE16
  assign keys = keys_ff;
endmodule

// ### verif/oms_pwr_model.sv
// oms_pwr_model.sv: power chip and keyboard stand-in for the sequencer
// assumes: bench sets the levels; key matrix has pull-downs on columns
`timescale 1ns/100ps
module oms_pwr_model (
  // bench controls
  input wire logic backup_ok,
  input wire logic adapter_ok,
  input wire logic wake_req,
  input wire logic [15:0] keys_held,
  // lines to the sequencer
  output logic supply_good,
  output logic adapter_valid,
  output logic onoff_key,
  output logic serial_wake,
  input wire logic [3:0] key_rows,
  output logic [3:0] key_cols
);
  // --------------------------------------------
  // supply lines
  // --------------------------------------------
  assign supply_good = backup_ok;
  assign adapter_valid = adapter_ok;
  // key debounce far outlasts the run, so switch-on goes via serial wake
  assign onoff_key = 1'b0;
  assign serial_wake = wake_req;
  // --------------------------------------------
  // matrix: an undriven row pulls its columns low
  // --------------------------------------------
  always_comb begin
    key_cols = 4'h0;
    for (int r = 0; r < 4; r++) begin
      if (key_rows[r]) begin
        key_cols = key_cols | keys_held[r*4 +: 4];
      end
    end
  end
endmodule

// ### verif/tb_top.sv
// tb_top.sv: self-checking bench for the operating mode sequencer
// assumes: design and model compiled first, 100 MHz pclk
`timescale 1ns/100ps
`include "oms_consts.svh"
module tb_top;
  typedef struct packed {
    logic adp;
    logic [7:0] ctrl;
    logic wake;
    logic [2:0] mode;
    logic [2:0] pwr;
    logic [2:0] pmask;
  } oms_row_type;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic backup_ok, adapter_ok, wake_req, rtc_run;
  logic supply_good, adapter_valid, onoff_key, serial_wake;
  logic [15:0] keys_held;
  logic [3:0] key_rows, key_cols;
  logic [2:0] mode;
  oms_pkg::oms_pwr_type pwr_ctrl;
  oms_row_type rows [7];
  int mismatches, checked;

  oms_seq uut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .supply_good(supply_good),
    .adapter_valid(adapter_valid), .onoff_key(onoff_key),
    .serial_wake(serial_wake), .key_rows(key_rows),
    .key_cols(key_cols), .pwr_ctrl(pwr_ctrl), .rtc_run(rtc_run),
    .mode(mode));
  oms_pwr_model far_side (.backup_ok(backup_ok),
    .adapter_ok(adapter_ok), .wake_req(wake_req),
    .keys_held(keys_held), .supply_good(supply_good),
    .adapter_valid(adapter_valid), .onoff_key(onoff_key),
    .serial_wake(serial_wake), .key_rows(key_rows),
    .key_cols(key_cols));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic stop_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // one apb transfer; request held until pready is seen high or 50 cycles pass
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready_wait", 32'h1, 32'h0);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic stat;
    apb(1'b0, `OMS_STAT_OFS, 32'h0);
  endtask

  // drop supply-good, check the idle state, then let it come back
  task automatic pcyc;
    @(posedge pclk);
    backup_ok <= 1'b0;
    adapter_ok <= 1'b0;
    wake_req <= 1'b0;
    cyc(2);
    chk("idle_mode", 32'(oms_pkg::OMS_IDLE), 32'(mode));
    chk("idle_out", 32'h0, {28'h0, pwr_ctrl, rtc_run});
    chk("idle_rows", 32'h1, 32'(key_rows));
    backup_ok <= 1'b1;
    cyc(6);
    chk("off_mode", 32'(oms_pkg::OMS_OFF), 32'(mode));
    chk("rtc_run", 32'h1, 32'(rtc_run));
  endtask

  task automatic turn_on;
    wake_req <= 1'b1;
    cyc(8);
    wake_req <= 1'b0;
    cyc(100);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    backup_ok = 1'b1;
    adapter_ok = 1'b0;
    wake_req = 1'b0;
    keys_held = 16'h0000;
    mismatches = 0;
    checked = 0;
    // ctrl bit0 firmware ok, bit1 battery, bit2 battery low
    rows[0] = '{1'b0, 8'h03, 1'b0, oms_pkg::OMS_OFF, 3'h0, 3'h4};
    rows[1] = '{1'b1, 8'h03, 1'b0, oms_pkg::OMS_CHARGE, 3'h2, 3'h6};
    rows[2] = '{1'b1, 8'h03, 1'b1, oms_pkg::OMS_OPCHG, 3'h6, 3'h6};
    rows[3] = '{1'b0, 8'h03, 1'b1, oms_pkg::OMS_OPER, 3'h4, 3'h4};
    rows[4] = '{1'b1, 8'h02, 1'b0, oms_pkg::OMS_MASK, 3'h0, 3'h0};
    rows[5] = '{1'b0, 8'h02, 1'b1, oms_pkg::OMS_MASK, 3'h0, 3'h0};
    rows[6] = '{1'b0, 8'h07, 1'b1, oms_pkg::OMS_OFF, 3'h0, 3'h4};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped_err", 32'h1, 32'(err));
    chk("unmapped_rd", 32'h0, rd);
    foreach (rows[i]) begin
      pcyc();
      apb(1'b1, `OMS_CTRL_OFS, 32'(rows[i].ctrl));
      adapter_ok <= rows[i].adp;
      if (rows[i].wake) turn_on();
      else cyc(108);
      chk("mode", 32'(rows[i].mode), 32'(mode));
      chk("pwr", 32'(rows[i].pwr), 32'(pwr_ctrl & rows[i].pmask));
      stat();
      chk("stat_mode", 32'(rows[i].mode), 32'(rd[2:0]));
    end
    // held up and right keys at switch-on force the boot-only mode
    pcyc();
    keys_held <= 16'h0003;
    apb(1'b1, `OMS_CTRL_OFS, 32'h3);
    cyc(4500);
    chk("rows_onehot", 32'h1, 32'($countones(key_rows)));
    apb(1'b0, `OMS_KEY_OFS, 32'h0);
    chk("keys", 32'h3, 32'(rd[15:0]));
    turn_on();
    chk("key_mask", 32'(oms_pkg::OMS_MASK), 32'(mode));
    keys_held <= 16'h0000;
    // partial cycles: 49 leave the flag clear, the 50th sets it
    pcyc();
    apb(1'b1, `OMS_CTRL_OFS, 32'h3);
    repeat (49) apb(1'b1, `OMS_CTRL_OFS, 32'h0b);
    stat();
    chk("need_49", 32'h0, 32'(rd[6]));
    apb(1'b1, `OMS_CTRL_OFS, 32'h0b);
    stat();
    chk("need_50", 32'h1, 32'(rd[6]));
    adapter_ok <= 1'b1;
    turn_on();
    stat();
    chk("prompt", 32'h1, 32'(rd[7]));
    chk("opchg", 32'(oms_pkg::OMS_OPCHG), 32'(rd[2:0]));
    apb(1'b1, `OMS_CTRL_OFS, 32'h23);
    stat();
    chk("phase_chg1", 32'h1, 32'(rd[9:8]));
    apb(1'b1, `OMS_CTRL_OFS, 32'h43);
    stat();
    chk("phase_dis", 32'h2, 32'(rd[9:8]));
    chk("discharge", 32'h1, 32'(pwr_ctrl.batt_discharge));
    apb(1'b1, `OMS_CTRL_OFS, 32'h43);
    stat();
    chk("phase_chg2", 32'h3, 32'(rd[9:8]));
    apb(1'b1, `OMS_CTRL_OFS, 32'h43);
    stat();
    chk("phase_end", 32'h0, 32'(rd[9:8]));
    // three month ticks
    pcyc();
    apb(1'b1, `OMS_CTRL_OFS, 32'h3);
    repeat (2) apb(1'b1, `OMS_CTRL_OFS, 32'h13);
    stat();
    chk("need_m2", 32'h0, 32'(rd[6]));
    apb(1'b1, `OMS_CTRL_OFS, 32'h13);
    stat();
    chk("need_m3", 32'h1, 32'(rd[6]));
    // battery removal and a refresh start in the same write; the start is ignored while off
    pcyc();
    apb(1'b1, `OMS_CTRL_OFS, 32'h3);
    apb(1'b1, `OMS_CTRL_OFS, 32'h21);
    stat();
    chk("need_removed", 32'h1, 32'(rd[6]));
    chk("start_off", 32'h0, 32'(rd[9:8]));
    stop_test();
  end

  // the whole sequence needs roughly 6000 cycles
  initial begin
    #200000;
    mismatches++;
    stop_test();
  end
endmodule
